// ==== design/pcr_pkg.sv ====
// Constants for the protection and configuration register block
package pcr_pkg;
    // ==========================================================
    // Device address byte
    localparam logic [3:0] DEV_TYPE_ID = 4'hB;
    localparam int DEV_TYPE_MSB = 7;
    localparam int DEV_TYPE_LSB = 4;
    localparam int DEV_PIN_MSB = 3;
    localparam int DEV_PIN_LSB = 2;
    localparam int DEV_RW_BIT = 0;
    // ==========================================================
    // Word address high byte qualifier bits (A15, A11, A10)
    localparam int WA_A15_BIT = 7;
    localparam int WA_A11_BIT = 3;
    localparam int WA_A10_BIT = 2;
    // ==========================================================
    // Register layout
    localparam int CFG_W = 16;
    localparam int ECS_BIT = 15;
    localparam int MODE_BIT = 9;
    localparam int LOCK_BIT = 8;
    localparam int ZONE_MSB = 7;
    localparam int ZONE_LSB = 0;
    localparam logic [15:0] CFG_WRITE_MASK = 16'h03FF;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    // ==========================================================
    // Protection geometry
    localparam int NUM_ZONES = 8;
    localparam int ZONE_BYTES = 8192;
    localparam int ARRAY_ADDR_W = 16;
    // ==========================================================
    // Transfer phases and bit counts
    localparam logic [2:0] PH_DEV = 3'h0;
    localparam logic [2:0] PH_WA_HI = 3'h1;
    localparam logic [2:0] PH_WA_LO = 3'h2;
    localparam logic [2:0] PH_DATA_HI = 3'h3;
    localparam logic [2:0] PH_DATA_LO = 3'h4;
    localparam logic [2:0] PH_EXTRA = 3'h5;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    typedef enum logic [4:0] {
        PCR_IDLE = 5'h01,
        PCR_RX = 5'h02,
        PCR_ACK = 5'h04,
        PCR_TX = 5'h08,
        PCR_RACK = 5'h10
    } pcr_state_t;
endpackage

// ==== design/pcr_line_if.sv ====
// Bus line events passed from the line sampler to the register engine
interface pcr_line_if;
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
    modport src (output start, output stop, output scl_rise, output scl_fall, output sda);
    modport snk (input start, input stop, input scl_rise, input scl_fall, input sda);
endinterface

// ==== design/pcr_bitrx.sv ====
// Two-wire line sampler: start, stop and clock edge detection
module pcr_bitrx (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    pcr_line_if.src line
);
    logic scl_q;
    logic scl_d;
    logic sda_q;
    logic sda_d;

    // ==========================================================
    // Edge and condition decode
    always_comb begin
        scl_d = scl_in;
        sda_d = sda_in;
        line.start = scl_q & scl_in & sda_q & ~sda_in;
        line.stop = scl_q & scl_in & ~sda_q & sda_in;
        line.scl_rise = ~scl_q & scl_in;
        line.scl_fall = scl_q & ~scl_in;
        line.sda = sda_in;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end
endmodule

// ==== design/pcr_zone.sv ====
// Write protection decision for the array and the security register
module pcr_zone #(
    parameter int ADDR_W = pcr_pkg::ARRAY_ADDR_W,
    parameter int ZONE_BYTES = pcr_pkg::ZONE_BYTES,
    parameter int NZONES = pcr_pkg::NUM_ZONES
) (
    input wire logic mode_enh,
    input wire logic [NZONES-1:0] zone_bits,
    input wire logic wp_pin,
    input wire logic [ADDR_W-1:0] wr_addr,
    output logic arr_prot,
    output logic sec_prot
);
    localparam int ZSH = $clog2(ZONE_BYTES);
    localparam int IDX_W = ADDR_W - ZSH;

    if (IDX_W < 1 || (1 << IDX_W) != NZONES || (1 << ZSH) != ZONE_BYTES) begin : g_bad
        $error("pcr_zone: zone geometry does not fit the address width");
    end

    logic [IDX_W-1:0] idx;
    logic [NZONES-1:0] hit;

    assign idx = wr_addr[ADDR_W-1:ZSH];

    // ==========================================================
    // Per-zone match, each zone independent
    for (genvar i = 0; i < NZONES; i++) begin : g_zone
        assign hit[i] = zone_bits[i] & (idx == IDX_W'(i));
    end

    always_comb begin
        if (mode_enh) begin
            arr_prot = |hit;
            sec_prot = 1'b0;
        end else begin
            arr_prot = wp_pin;
            sec_prot = wp_pin;
        end
    end
endmodule

// ==== design/pcr_top.sv ====
// Protection and configuration register with its two-wire access engine
// Function
// - The register is selected by a device address byte of type 1011, the two address pin bits, a don't-care and R/W.
// - The word address is two bytes with A15 and A11 one and A10 zero; all other word address bits are ignored.
// - Register data moves as two bytes after the word address, bits 15..8 first, then bits 7..0.
// - After each array read the ECC-used flag takes one if correction was needed and zero if not.
// - Once one, the ECC-used flag stays one until a later read needs no correction or reset clears it.
// - The ECC-used flag is zero after reset and after any read that did not invoke correction.
// - Bits 14 to 10 are unimplemented and always read zero.
// - With the mode select bit one, the write-protect pin is ignored and the zone bits protect the array.
// - With the mode select bit zero, the write-protect pin protects the whole array and the security register.
// - With the lock bit one the register is read-only until reset clears the lock; with it zero writes are accepted.
// - In enhanced mode the array is split into eight independent zones of 8192 bytes each.
// - Bits 7 to 0 are eight readable and writable zone protect bits, one per zone.
module pcr_top #(
    parameter int ADDR_W = pcr_pkg::ARRAY_ADDR_W,
    parameter int NZONES = pcr_pkg::NUM_ZONES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] addr_pins,
    input wire logic wp_pin,
    input wire logic rd_done,
    input wire logic rd_ecc_used,
    input wire logic [ADDR_W-1:0] wr_addr,
    output logic array_protect,
    output logic secreg_protect,
    output logic ecc_used_flag,
    output logic protect_mode_select,
    output logic cfg_locked,
    output logic [NZONES-1:0] zone_protect_bits
);
    if (NZONES != pcr_pkg::NUM_ZONES) begin : g_bad
        $error("pcr_top: zone bit count must match the register layout");
    end

    pcr_line_if line ();

    pcr_bitrx u_bitrx (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .line(line)
    );

    // ==========================================================
    // State
    pcr_pkg::pcr_state_t state_q;
    pcr_pkg::pcr_state_t state_d;
    logic [3:0] bit_cnt_q;
    logic [3:0] bit_cnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [2:0] phase_q;
    logic [2:0] phase_d;
    logic rw_q;
    logic rw_d;
    logic wa_ok_q;
    logic wa_ok_d;
    logic tx_lo_q;
    logic tx_lo_d;
    logic mack_q;
    logic mack_d;
    logic [7:0] hold_hi_q;
    logic [7:0] hold_hi_d;
    logic oe_q;
    logic oe_d;
    logic ecs_q;
    logic ecs_d;
    logic mode_q;
    logic mode_d;
    logic lock_q;
    logic lock_d;
    logic [NZONES-1:0] zone_q;
    logic [NZONES-1:0] zone_d;
    logic arr_prot_q;
    logic sec_prot_q;
    logic arr_prot_c;
    logic sec_prot_c;

    logic [15:0] cfg_rd;
    logic [15:0] cfg_wr;
    logic [15:0] cfg_cur;
    logic [7:0] tx_byte;
    logic dev_match;

    // ==========================================================
    // Register image
    always_comb begin
        cfg_cur = pcr_pkg::CFG_RESET;
        cfg_cur[pcr_pkg::ECS_BIT] = ecs_q;
        cfg_cur[pcr_pkg::MODE_BIT] = mode_q;
        cfg_cur[pcr_pkg::LOCK_BIT] = lock_q;
        cfg_cur[pcr_pkg::ZONE_MSB:pcr_pkg::ZONE_LSB] = zone_q;
        cfg_rd = cfg_cur & (pcr_pkg::CFG_WRITE_MASK | (16'h0001 << pcr_pkg::ECS_BIT));
        cfg_wr = {hold_hi_q, shift_q};
        // Byte that follows the one just sent
        tx_byte = tx_lo_q ? cfg_rd[15:8] : cfg_rd[7:0];
        dev_match = (shift_q[pcr_pkg::DEV_TYPE_MSB:pcr_pkg::DEV_TYPE_LSB] == pcr_pkg::DEV_TYPE_ID)
                    && (shift_q[pcr_pkg::DEV_PIN_MSB:pcr_pkg::DEV_PIN_LSB] == addr_pins);
    end

    // ==========================================================
    // Transfer engine and register update
    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        phase_d = phase_q;
        rw_d = rw_q;
        wa_ok_d = wa_ok_q;
        tx_lo_d = tx_lo_q;
        mack_d = mack_q;
        hold_hi_d = hold_hi_q;
        oe_d = oe_q;
        ecs_d = ecs_q;
        mode_d = mode_q;
        lock_d = lock_q;
        zone_d = zone_q;
        if (rd_done) begin
            ecs_d = rd_ecc_used;
        end
        if (line.stop) begin
            state_d = pcr_pkg::PCR_IDLE;
            oe_d = 1'b0;
        end else if (line.start) begin
            state_d = pcr_pkg::PCR_RX;
            bit_cnt_d = 4'h0;
            phase_d = pcr_pkg::PH_DEV;
            oe_d = 1'b0;
        end else begin
            case (state_q)
                pcr_pkg::PCR_IDLE: begin
                    oe_d = 1'b0;
                end
                pcr_pkg::PCR_RX: begin
                    if (line.scl_rise && bit_cnt_q != pcr_pkg::BITS_PER_BYTE) begin
                        shift_d = {shift_q[6:0], line.sda};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (line.scl_fall && bit_cnt_q == pcr_pkg::BITS_PER_BYTE) begin
                        state_d = pcr_pkg::PCR_ACK;
                        oe_d = 1'b1;
                        case (phase_q)
                            pcr_pkg::PH_DEV: begin
                                if (dev_match) begin
                                    rw_d = shift_q[pcr_pkg::DEV_RW_BIT];
                                end else begin
                                    state_d = pcr_pkg::PCR_IDLE;
                                    oe_d = 1'b0;
                                end
                            end
                            pcr_pkg::PH_WA_HI: begin
                                wa_ok_d = shift_q[pcr_pkg::WA_A15_BIT] & shift_q[pcr_pkg::WA_A11_BIT]
                                          & ~shift_q[pcr_pkg::WA_A10_BIT];
                            end
                            pcr_pkg::PH_DATA_HI: begin
                                hold_hi_d = shift_q;
                            end
                            pcr_pkg::PH_DATA_LO: begin
                                if (wa_ok_q && !lock_q) begin
                                    mode_d = cfg_wr[pcr_pkg::MODE_BIT];
                                    lock_d = cfg_wr[pcr_pkg::LOCK_BIT];
                                    zone_d = cfg_wr[pcr_pkg::ZONE_MSB:pcr_pkg::ZONE_LSB];
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                pcr_pkg::PCR_ACK: begin
                    if (line.scl_fall) begin
                        if (phase_q == pcr_pkg::PH_DEV && rw_q) begin
                            state_d = pcr_pkg::PCR_TX;
                            tx_lo_d = 1'b0;
                            oe_d = ~cfg_rd[15];
                            shift_d = {cfg_rd[14:8], 1'b0};
                            bit_cnt_d = 4'h1;
                        end else begin
                            state_d = pcr_pkg::PCR_RX;
                            oe_d = 1'b0;
                            bit_cnt_d = 4'h0;
                            if (phase_q != pcr_pkg::PH_EXTRA) begin
                                phase_d = phase_q + 3'h1;
                            end
                        end
                    end
                end
                pcr_pkg::PCR_TX: begin
                    if (line.scl_fall) begin
                        if (bit_cnt_q == pcr_pkg::BITS_PER_BYTE) begin
                            state_d = pcr_pkg::PCR_RACK;
                            oe_d = 1'b0;
                        end else begin
                            oe_d = ~shift_q[7];
                            shift_d = {shift_q[6:0], 1'b0};
                            bit_cnt_d = bit_cnt_q + 4'h1;
                        end
                    end
                end
                pcr_pkg::PCR_RACK: begin
                    if (line.scl_rise) begin
                        mack_d = ~line.sda;
                    end else if (line.scl_fall) begin
                        if (mack_q) begin
                            state_d = pcr_pkg::PCR_TX;
                            tx_lo_d = ~tx_lo_q;
                            oe_d = ~tx_byte[7];
                            shift_d = {tx_byte[6:0], 1'b0};
                            bit_cnt_d = 4'h1;
                        end else begin
                            state_d = pcr_pkg::PCR_IDLE;
                        end
                    end
                end
                default: begin
                    state_d = pcr_pkg::PCR_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    pcr_zone #(
        .ADDR_W(ADDR_W),
        .ZONE_BYTES(pcr_pkg::ZONE_BYTES),
        .NZONES(NZONES)
    ) u_zone (
        .mode_enh(mode_q),
        .zone_bits(zone_q),
        .wp_pin(wp_pin),
        .wr_addr(wr_addr),
        .arr_prot(arr_prot_c),
        .sec_prot(sec_prot_c)
    );

    // ==========================================================
    // Transfer engine registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= pcr_pkg::PCR_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            phase_q <= pcr_pkg::PH_DEV;
            rw_q <= 1'b0;
            wa_ok_q <= 1'b0;
            tx_lo_q <= 1'b0;
            mack_q <= 1'b0;
            hold_hi_q <= 8'h00;
            oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            phase_q <= phase_d;
            rw_q <= rw_d;
            wa_ok_q <= wa_ok_d;
            tx_lo_q <= tx_lo_d;
            mack_q <= mack_d;
            hold_hi_q <= hold_hi_d;
            oe_q <= oe_d;
        end
    end

    // ==========================================================
    // Register contents
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ecs_q <= pcr_pkg::CFG_RESET[pcr_pkg::ECS_BIT];
            mode_q <= pcr_pkg::CFG_RESET[pcr_pkg::MODE_BIT];
            lock_q <= pcr_pkg::CFG_RESET[pcr_pkg::LOCK_BIT];
            zone_q <= pcr_pkg::CFG_RESET[pcr_pkg::ZONE_MSB:pcr_pkg::ZONE_LSB];
        end else begin
            ecs_q <= ecs_d;
            mode_q <= mode_d;
            lock_q <= lock_d;
            zone_q <= zone_d;
        end
    end

    // ==========================================================
    // Protection outputs, one cycle behind their inputs
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            arr_prot_q <= 1'b0;
            sec_prot_q <= 1'b0;
        end else begin
            arr_prot_q <= arr_prot_c;
            sec_prot_q <= sec_prot_c;
        end
    end

    // Open-drain: line is only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
    assign array_protect = arr_prot_q;
    assign secreg_protect = sec_prot_q;
    assign ecc_used_flag = ecs_q;
    assign protect_mode_select = mode_q;
    assign cfg_locked = lock_q;
    assign zone_protect_bits = zone_q;
endmodule

// ==== verif/pcr_chk.sv ====
// Concurrent checks on the ports of the protection register block
module pcr_chk #(
    parameter int ADDR_W = 16,
    parameter int NZONES = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_oe,
    input wire logic wp_pin,
    input wire logic rd_done,
    input wire logic rd_ecc_used,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic array_protect,
    input wire logic secreg_protect,
    input wire logic ecc_used_flag,
    input wire logic protect_mode_select,
    input wire logic cfg_locked,
    input wire logic [NZONES-1:0] zone_protect_bits
);
    // ==========================================================
    // Helpers
    logic zone_hit;
    assign zone_hit = zone_protect_bits[wr_addr[ADDR_W-1 -: 3]];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence ecc_seen_s;
        rd_done && rd_ecc_used;
    endsequence
    sequence ecc_clean_s;
        rd_done && !rd_ecc_used;
    endsequence
    // ==========================================================
    // Assertions
    a_ecc_set_flag: assert property (ecc_seen_s |=> ecc_used_flag)
        else $error("ecc flag not set after corrected read");
    a_ecc_flag_hold: assert property (!rd_done |=> $stable(ecc_used_flag))
        else $error("ecc flag changed without a read");
    a_ecc_flag_clear: assert property (ecc_clean_s |=> !ecc_used_flag)
        else $error("ecc flag not cleared after clean read");
    a_lock_keeps_all: assert property (
        cfg_locked |=> cfg_locked && $stable(zone_protect_bits) && $stable(protect_mode_select))
        else $error("locked register changed");
    a_enh_zone_prot: assert property (protect_mode_select |=> array_protect == $past(zone_hit))
        else $error("zone protection mismatch");
    a_legacy_wp_prot: assert property (
        !protect_mode_select |=> array_protect == $past(wp_pin) && secreg_protect == $past(wp_pin))
        else $error("legacy protection mismatch");
    a_ack_after_fall: assert property ($rose(sda_oe) |-> !$past(scl_in))
        else $error("data line driven outside clock low");
    a_idle_no_update: assert property (scl_in [*6] |-> $stable(zone_protect_bits))
        else $error("zone bits changed while bus clock high");
endmodule

bind pcr_top pcr_chk #(.ADDR_W(ADDR_W), .NZONES(NZONES)) pcr_chk_inst (.core_clk(core_clk), .arst_n(arst_n),
    .scl_in(scl_in), .sda_oe(sda_oe), .wp_pin(wp_pin), .rd_done(rd_done), .rd_ecc_used(rd_ecc_used),
    .wr_addr(wr_addr), .array_protect(array_protect), .secreg_protect(secreg_protect),
    .ecc_used_flag(ecc_used_flag), .protect_mode_select(protect_mode_select), .cfg_locked(cfg_locked),
    .zone_protect_bits(zone_protect_bits));

// ==== verif/pcr_host_bfm.sv ====
// Two-wire host model driving the bus clock and data lines
module pcr_host_bfm (
    input wire logic core_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl <= 1'b1;
        sda <= 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Start or repeated start: data falls while clock high
    task automatic start_c();
        sda <= 1'b1;
        hold(2);
        scl <= 1'b1;
        hold(4);
        sda <= 1'b0;
        hold(4);
        scl <= 1'b0;
        hold(4);
    endtask
    task automatic stop_c();
        sda <= 1'b0;
        hold(4);
        scl <= 1'b1;
        hold(4);
        sda <= 1'b1;
        hold(4);
    endtask
    // Data set in clock low, sampled at clock high
    task automatic clk_bit(input logic b, output logic r);
        sda <= b;
        hold(4);
        scl <= 1'b1;
        hold(4);
        r = sda_line;
        scl <= 1'b0;
        hold(4);
    endtask
    // Byte out msb first, then release for acknowledge
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
        clk_bit(1'b1, r);
        ack = !r;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
        clk_bit(last, r);
    endtask
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the protection register block
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Signals
    logic core_clk;
    logic arst_n;
    logic sda_out;
    logic [1:0] pins;
    logic scl, sda_h, sda_oe, sda_line, wp_pin, rd_done, rd_ecc_used;
    logic array_protect, secreg_protect, ecc_used_flag, protect_mode_select, cfg_locked;
    logic [15:0] wr_addr;
    logic [7:0] zone_protect_bits;
    logic [15:0] v;
    logic ak;
    int n_fail = 0;
    int n_compared = 0;
    localparam logic [1:0] PINS = 2'h2;
    localparam logic [7:0] DEV_W = {4'hB, PINS, 2'h0};
    localparam logic [7:0] DEV_R = {4'hB, PINS, 2'h1};
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Open drain line with pull-up
    assign sda_line = sda_h & (~sda_oe | sda_out);
    pcr_host_bfm pcr_host_bfm_inst (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda(sda_h));
    pcr_top pcr_top_inst (.core_clk(core_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_pins(pins), .wp_pin(wp_pin), .rd_done(rd_done),
        .rd_ecc_used(rd_ecc_used), .wr_addr(wr_addr), .array_protect(array_protect),
        .secreg_protect(secreg_protect), .ecc_used_flag(ecc_used_flag),
        .protect_mode_select(protect_mode_select), .cfg_locked(cfg_locked),
        .zone_protect_bits(zone_protect_bits));
    // ==========================================================
    // Tasks
    task automatic tally_and_finish();
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] dv, input logic [7:0] wah, input logic [15:0] d, output logic ok);
        logic a;
        pcr_host_bfm_inst.start_c();
        pcr_host_bfm_inst.put_byte(dv, ok);
        if (ok) begin
            pcr_host_bfm_inst.put_byte(wah, a);
            pcr_host_bfm_inst.put_byte(8'h00, a);
            pcr_host_bfm_inst.put_byte(d[15:8], a);
            pcr_host_bfm_inst.put_byte(d[7:0], a);
        end
        pcr_host_bfm_inst.stop_c();
        pcr_host_bfm_inst.hold(6);
    endtask
    task automatic reg_rd(output logic [15:0] d);
        logic a;
        pcr_host_bfm_inst.start_c();
        pcr_host_bfm_inst.put_byte(DEV_W, a);
        pcr_host_bfm_inst.put_byte(8'h88, a);
        pcr_host_bfm_inst.put_byte(8'h00, a);
        pcr_host_bfm_inst.start_c();
        pcr_host_bfm_inst.put_byte(DEV_R, a);
        pcr_host_bfm_inst.get_byte(1'b0, d[15:8]);
        pcr_host_bfm_inst.get_byte(1'b1, d[7:0]);
        pcr_host_bfm_inst.stop_c();
        pcr_host_bfm_inst.hold(6);
    endtask
    task automatic ecc_read(input logic used);
        rd_done <= 1'b1;
        rd_ecc_used <= used;
        pcr_host_bfm_inst.hold(1);
        rd_done <= 1'b0;
        pcr_host_bfm_inst.hold(2);
    endtask
    // ==========================================================
    // Sequence
    initial begin
        repeat (50000) @(posedge core_clk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        arst_n <= 1'b0;
        pins <= PINS;
        wp_pin <= 1'b0;
        rd_done <= 1'b0;
        rd_ecc_used <= 1'b0;
        wr_addr <= 16'h0000;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        pcr_host_bfm_inst.hold(3);
        `CHK({ecc_used_flag, protect_mode_select, cfg_locked, zone_protect_bits}, 11'h000)
        reg_wr(DEV_W, 8'h88, 16'hFEA5, ak);
        `CHK(ak, 1'b1)
        `CHK({protect_mode_select, cfg_locked, zone_protect_bits}, 10'h2A5)
        reg_rd(v);
        `CHK(v, 16'h02A5)
        reg_wr(8'hA4, 8'h88, 16'h0000, ak);
        `CHK(ak, 1'b0)
        reg_wr({4'hB, ~PINS, 2'h0}, 8'h88, 16'h0000, ak);
        `CHK(ak, 1'b0)
        reg_wr(DEV_W, 8'h8C, 16'h0000, ak);
        reg_wr(DEV_W, 8'h08, 16'h0000, ak);
        `CHK(zone_protect_bits, 8'hA5)
        wp_pin <= 1'b1;
        for (int z = 0; z < 8; z++) begin
            wr_addr <= {z[2:0], 13'h1FFF};
            pcr_host_bfm_inst.hold(2);
            `CHK(array_protect, 1'(8'hA5 >> z))
            `CHK(secreg_protect, 1'b0)
        end
        ecc_read(1'b1);
        `CHK(ecc_used_flag, 1'b1)
        pcr_host_bfm_inst.hold(20);
        reg_rd(v);
        `CHK(v, 16'h82A5)
        ecc_read(1'b0);
        `CHK(ecc_used_flag, 1'b0)
        reg_wr(DEV_W, 8'h88, 16'h0000, ak);
        for (int w = 0; w < 2; w++) begin
            wp_pin <= w[0];
            pcr_host_bfm_inst.hold(2);
            `CHK({array_protect, secreg_protect}, {2{w[0]}})
        end
        reg_wr(DEV_W, 8'h88, 16'h013C, ak);
        `CHK(cfg_locked, 1'b1)
        reg_wr(DEV_W, 8'h88, 16'h02FF, ak);
        reg_rd(v);
        `CHK(v, 16'h013C)
        `CHK(sda_out, 1'b0)
        // Reset in mid-run clears flag, lock and zones
        ecc_read(1'b1);
        arst_n <= 1'b0;
        pcr_host_bfm_inst.hold(2);
        arst_n <= 1'b1;
        pins <= 2'h1;
        pcr_host_bfm_inst.hold(3);
        `CHK({ecc_used_flag, protect_mode_select, cfg_locked, zone_protect_bits}, 11'h000)
        reg_wr(DEV_W, 8'h88, 16'h0001, ak);
        `CHK(ak, 1'b0)
        reg_wr({4'hB, 2'h1, 2'h0}, 8'h88, 16'h0001, ak);
        `CHK(ak, 1'b1)
        `CHK(zone_protect_bits, 8'h01)
        tally_and_finish();
    end
endmodule
